//--- design/dlc_map.svh
// register offsets, field positions, reset values and beam limits of the list coprocessor
`ifndef DLC_MAP_SVH
`define DLC_MAP_SVH
`define DLC_OFF_L1H       8'h00
`define DLC_OFF_L1L       8'h04
`define DLC_OFF_L2H       8'h08
`define DLC_OFF_L2L       8'h0c
`define DLC_OFF_JMP1      8'h10
`define DLC_OFF_JMP2      8'h14
`define DLC_OFF_CTRL      8'h18
`define DLC_OFF_CFG       8'h1c
`define DLC_OFF_STATUS    8'h20
`define DLC_OFF_BEAM      8'h24
`define DLC_OFF_L1LOC     8'h28
`define DLC_OFF_L2LOC     8'h2c
`define DLC_CTRL_DANGER   1
`define DLC_CFG_PAL       0
`define DLC_CFG_LACE      1
`define DLC_CFG_RUN       2
`define DLC_CFG_RST       3'b000
`define DLC_H_LAST_LONG   8'he3
`define DLC_H_LAST_SHORT  8'he2
`define DLC_V_LAST_NTSC   9'd261
`define DLC_V_LAST_PAL    9'd311
`define DLC_GUARD_NEVER   9'h010
`define DLC_GUARD_ALWAYS  9'h020
`define DLC_CR_L1H        9'h040
`define DLC_CR_L1L        9'h042
`define DLC_CR_L2H        9'h044
`define DLC_CR_L2L        9'h046
`define DLC_CR_JMP1       9'h048
`define DLC_CR_JMP2       9'h04a
`define DLC_PC_STEP       19'd2
`define DLC_SKIP_STEP     19'd6
`define DLC_IR_KIND       0
`define DLC_ST_LSB        24
`define DLC_BM_H_LSB      16
`define DLC_BM_LONG_LINE  24
`define DLC_BM_LONG_FIELD 25
`endif

//--- design/dlc_pkg.sv
// types shared by the list coprocessor design
package dlc_pkg;
  typedef enum logic [3:0] {
    DLC_ST_IDLE    = 4'b0001,
    DLC_ST_FETCH_A = 4'b0010,
    DLC_ST_FETCH_B = 4'b0100,
    DLC_ST_WAIT    = 4'b1000
  } dlc_state_t;
endpackage

//--- design/dlc_top.sv
// display list coprocessor: beam counters, instruction sequencer and ahb-lite register slave
`include "dlc_map.svh"

// Functional notes
// - horizontal count runs 0 to e2 hex, e3 on long lines; its lsb is ignored, giving 114 positions.
// - ntsc lines alternate 228 and 227 clocks; pal lines are all 227.
// - vertical compare uses low eight count bits, so line 256 compares as zero.
// - field has 262 or 312 lines; interlace alternates 262/263 or 312/313.
// - ntsc interlace repeats a four-field pattern of short and long endings.
// - horizontal count advances by one on every system clock cycle.
// - two list locations, each a 3-bit high part and 16-bit low part.
// - high part sits lower; one long write to the location offset loads the whole address.
// - fetch at the program counter, increment after each fetch, run sequentially.
// - a jump strobe loads the counter from its location; next fetch goes there.
// - every vertical blank reloads the counter from list one, even mid-wait.
// - list moves may write location registers and jump strobes themselves.
// - moves always allowed to 20-1fe hex, never to 00-0f hex.
// - danger bit at bit 1 opens 10-1f hex to moves when set.
// - reset clears the danger bit.
// - a wait ends once the beam is at or past its position.
// - any number of moves after a wait run back to back.
// - move has word one bit 0 clear, destination in bits 8-1, data in word two.
// - wait/skip has bit 0 set, vertical 15-8, horizontal 7-1, enables in word two.
// - skip has word two bit 0 set and skips the next instruction when true.
// - a position bit is compared only when its enable bit is one; the vertical msb is always compared.
module dlc_top
  import dlc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mem_req,
  output logic      [18:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             reg_wr_strobe,
  output logic      [8:0]  reg_wr_addr,
  output logic      [15:0] reg_wr_data,
  output logic      [7:0]  beam_h,
  output logic      [8:0]  beam_v
);

  // beam at or past target, honouring the per-bit enables; vertical msb is always compared
  function automatic logic beam_reached(input logic [7:0]  h,
                                        input logic [8:0]  v,
                                        input logic [15:0] w1,
                                        input logic [15:0] w2);
    logic [14:0] mask;
    logic [14:0] beam;
    mask = {1'b1, w2[14:1]};
    beam = {v[7:0], h[7:1]};
    return (beam & mask) >= (w1[15:1] & mask);
  endfunction

  // destination guard under the danger bit
  function automatic logic move_allowed(input logic [8:0] da,
                                        input logic       dang);
    return (da >= `DLC_GUARD_ALWAYS) || ((da >= `DLC_GUARD_NEVER) && dang);
  endfunction

  logic [2:0]  l1_hi;
  logic [15:0] l1_lo;
  logic [2:0]  l2_hi;
  logic [15:0] l2_lo;
  logic        danger_enable;
  logic [2:0]  cfg;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic [7:0]  hcount;
  logic [8:0]  vcount;
  logic        long_line;
  logic        long_field;
  dlc_state_t  state;
  dlc_state_t  next_state;
  logic [18:0] pc;
  logic [18:0] next_pc;
  logic [15:0] ir1;
  logic [15:0] ir2;
  logic [8:0]  move_da;
  logic        move_fire;

  wire         addr_phase = hsel & hready & htrans[1];
  wire         pal        = cfg[`DLC_CFG_PAL];
  wire         lace       = cfg[`DLC_CFG_LACE];
  wire         run        = cfg[`DLC_CFG_RUN];
  wire  [18:0] list1_location = {l1_hi, l1_lo[15:1], 1'b0};
  wire  [18:0] list2_location = {l2_hi, l2_lo[15:1], 1'b0};

  // ---------------- ahb-lite slave: zero wait states, always okay ----------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= addr_phase & hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  function automatic logic host_hit(input logic [7:0] off);
    return dp_wr && (dp_addr == off);
  endfunction

  // read data is latched in the address phase so it comes from a flop; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        `DLC_OFF_CTRL:   hrdata <= {30'h0, danger_enable, 1'b0};
        `DLC_OFF_CFG:    hrdata <= {29'h0, cfg};
        `DLC_OFF_STATUS: hrdata <= {4'h0, state, 5'h00, pc};
        `DLC_OFF_BEAM:   hrdata <= {6'h00, long_field, long_line, hcount, 7'h00, vcount};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      danger_enable <= 1'b0;
    end else if (host_hit(`DLC_OFF_CTRL)) begin
      danger_enable <= hwdata[`DLC_CTRL_DANGER];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `DLC_CFG_RST;
    end else if (host_hit(`DLC_OFF_CFG)) begin
      cfg <= hwdata[2:0];
    end
  end

  // ---------------- list location registers ----------------
  // host writes win over a same-cycle list move to the same register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      l1_hi <= 3'h0;
      l1_lo <= 16'h0000;
      l2_hi <= 3'h0;
      l2_lo <= 16'h0000;
    end else begin
      if (host_hit(`DLC_OFF_L1LOC)) begin
        l1_hi <= hwdata[18:16];
        l1_lo <= hwdata[15:0];
      end else begin
        if (host_hit(`DLC_OFF_L1H)) begin
          l1_hi <= hwdata[2:0];
        end else if (move_fire && move_da == `DLC_CR_L1H) begin
          l1_hi <= mem_rdata[2:0];
        end
        if (host_hit(`DLC_OFF_L1L)) begin
          l1_lo <= hwdata[15:0];
        end else if (move_fire && move_da == `DLC_CR_L1L) begin
          l1_lo <= mem_rdata;
        end
      end
      if (host_hit(`DLC_OFF_L2LOC)) begin
        l2_hi <= hwdata[18:16];
        l2_lo <= hwdata[15:0];
      end else begin
        if (host_hit(`DLC_OFF_L2H)) begin
          l2_hi <= hwdata[2:0];
        end else if (move_fire && move_da == `DLC_CR_L2H) begin
          l2_hi <= mem_rdata[2:0];
        end
        if (host_hit(`DLC_OFF_L2L)) begin
          l2_lo <= hwdata[15:0];
        end else if (move_fire && move_da == `DLC_CR_L2L) begin
          l2_lo <= mem_rdata;
        end
      end
    end
  end

  // ---------------- beam counters ----------------
  wire [7:0] h_last    = (!pal && long_line) ? `DLC_H_LAST_LONG : `DLC_H_LAST_SHORT;
  wire [8:0] v_last    = (pal ? `DLC_V_LAST_PAL : `DLC_V_LAST_NTSC)
                         + {8'h00, lace & long_field};
  wire       line_end  = (hcount >= h_last); // >= so a mode change mid-line cannot overrun
  wire       frame_end = line_end && (vcount >= v_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcount <= 8'h00;
      vcount <= 9'h000;
    end else if (line_end) begin
      hcount <= 8'h00;
      vcount <= frame_end ? 9'h000 : vcount + 9'h001;
    end else begin
      hcount <= hcount + 8'h01;
    end
  end

  // the toggles continue across field ends, which yields the four-field ntsc pattern
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_line  <= 1'b1;
      long_field <= 1'b0;
    end else begin
      if (line_end) begin
        long_line <= !pal && !long_line;
      end
      if (frame_end) begin
        long_field <= lace && !long_field;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beam_h <= 8'h00;
      beam_v <= 9'h000;
    end else begin
      beam_h <= hcount;
      beam_v <= vcount;
    end
  end

  // ---------------- instruction sequencer ----------------
  wire skip_hit = beam_reached(hcount, vcount, ir1, mem_rdata);
  wire wait_hit = beam_reached(hcount, vcount, ir1, ir2);
  wire word_b   = (state == DLC_ST_FETCH_B) && mem_ack;

  assign move_da   = {ir1[8:1], 1'b0};
  assign move_fire = word_b && !ir1[`DLC_IR_KIND]
                     && move_allowed(move_da, danger_enable);

  wire jump1 = host_hit(`DLC_OFF_JMP1) || (move_fire && move_da == `DLC_CR_JMP1);
  wire jump2 = host_hit(`DLC_OFF_JMP2) || (move_fire && move_da == `DLC_CR_JMP2);

  always_comb begin
    next_state = state;
    next_pc    = pc;
    case (state)
      DLC_ST_IDLE: begin
        next_state = DLC_ST_FETCH_A;
      end
      DLC_ST_FETCH_A: begin
        if (mem_ack) begin
          next_pc    = pc + `DLC_PC_STEP;
          next_state = DLC_ST_FETCH_B;
        end
      end
      DLC_ST_FETCH_B: begin
        if (mem_ack) begin
          next_pc    = pc + `DLC_PC_STEP;
          next_state = DLC_ST_FETCH_A;
          if (ir1[`DLC_IR_KIND]) begin
            if (mem_rdata[`DLC_IR_KIND]) begin
              if (skip_hit) begin
                next_pc = pc + `DLC_SKIP_STEP;
              end
            end else begin
              next_state = DLC_ST_WAIT;
            end
          end
        end
      end
      DLC_ST_WAIT: begin
        if (wait_hit) begin
          next_state = DLC_ST_FETCH_A;
        end
      end
      default: begin
        next_state = DLC_ST_IDLE;
      end
    endcase
    // vertical blank beats any jump; a jump beats normal flow
    if (frame_end) begin
      next_pc    = list1_location;
      next_state = DLC_ST_FETCH_A;
    end else if (jump1) begin
      next_pc    = list1_location;
      next_state = DLC_ST_FETCH_A;
    end else if (jump2) begin
      next_pc    = list2_location;
      next_state = DLC_ST_FETCH_A;
    end
    if (!run) begin
      next_state = DLC_ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= DLC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc <= 19'h00000;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir1 <= 16'h0000;
      ir2 <= 16'h0000;
    end else begin
      if (state == DLC_ST_FETCH_A && mem_ack) begin
        ir1 <= mem_rdata;
      end
      if (word_b) begin
        ir2 <= mem_rdata;
      end
    end
  end

  // the request decodes the state register only, so a jump or blank changes it one cycle later
  assign mem_req  = (state == DLC_ST_FETCH_A) || (state == DLC_ST_FETCH_B);
  assign mem_addr = pc;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_wr_strobe <= 1'b0;
      reg_wr_addr   <= 9'h000;
      reg_wr_data   <= 16'h0000;
    end else begin
      reg_wr_strobe <= move_fire;
      if (move_fire) begin
        reg_wr_addr <= move_da;
        reg_wr_data <= mem_rdata;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking dlc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_fetch_word;
    mem_req && mem_ack;
  endsequence
  sequence s_quiet;
    !frame_end && !jump1 && !jump2 && run;
  endsequence
  a_hcount_range:
  assert property (hcount <= `DLC_H_LAST_LONG
                   && (pal && !$changed(cfg) -> hcount <= `DLC_H_LAST_SHORT))
    else $error("horizontal count out of range");
  a_line_alternate:
  assert property (line_end && !pal && !$past(pal) |=> long_line == !$past(long_line))
    else $error("ntsc line length did not alternate");
  a_vcount_range:
  assert property (vcount <= v_last || $changed(cfg))
    else $error("vertical count beyond field length");
  a_danger_reset:
  assert property (@(posedge hclk) disable iff (1'b0) $rose(hresetn) |-> !danger_enable)
    else $error("danger bit not clear after reset");
  a_guard_low:
  assert property (reg_wr_strobe |-> reg_wr_addr >= `DLC_GUARD_NEVER)
    else $error("move reached a never-writable register");
  a_guard_danger:
  assert property (move_fire && move_da < `DLC_GUARD_ALWAYS |-> danger_enable ##1 reg_wr_strobe)
    else $error("protected range written without danger bit");
  a_vblank_reload:
  assert property (frame_end |=> pc == $past(list1_location))
    else $error("vertical blank did not reload the counter");
  a_jump_two:
  assert property (jump2 && !jump1 && !frame_end |=> pc == $past(list2_location))
    else $error("jump strobe two did not load list two");
  a_wait_quiet:
  assert property (state == DLC_ST_WAIT |-> !mem_req)
    else $error("memory requested during a wait");
  a_pc_step:
  assert property (s_fetch_word ##0 s_quiet ##0 state == DLC_ST_FETCH_A
                   |=> pc == $past(pc) + `DLC_PC_STEP)
    else $error("counter did not advance after a fetch");
  a_wait_done:
  assert property (state == DLC_ST_WAIT && wait_hit ##0 s_quiet |=> mem_req)
    else $error("satisfied wait did not resume fetching");
  a_vert_wrap:
  assert property (vcount == 9'd256 |-> beam_reached(hcount, vcount, 16'h0001, 16'hff00)
                   && !beam_reached(hcount, vcount, 16'h0101, 16'hff00))
    else $error("line 256 did not compare as zero");
endmodule

//--- test/dlc_mem_model.sv
// memory model that serves list instruction words to the coprocessor
module dlc_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req,
  input  wire logic [18:0] mem_addr,
  input  wire logic [3:0]  lat,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:1023];
  logic [3:0]  cnt;
  logic [15:0] last;
  // stall count grows while a request waits, so a slow memory stretches every word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 4'h0;
      last <= 16'h0000;
    end else if (mem_req && mem_ack) begin
      cnt  <= 4'h0;
      last <= mem_rdata;
    end else if (mem_req) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end
  // two words per instruction, first word at the lower address
  assign mem_ack   = mem_req && (cnt >= lat);
  // an unanswered bus shows the inverse of the last word so stale data never passes
  assign mem_rdata = mem_ack ? mem[mem_addr[10:1]] : ~last;
endmodule

//--- test/dlc_top_test.sv
// self-checking bench of the list coprocessor with a list interpreter model
`include "dlc_map.svh"
`define TB_CHECK(nm, ex, got) \
  begin \
    cmp_count++; \
    if (32'(got) !== 32'(ex)) begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, 32'(ex), 32'(got)); \
    end \
  end
module dlc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, loc2;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        mem_req, mem_ack, reg_wr_strobe, field_done;
  logic [18:0] mem_addr;
  logic [15:0] mem_rdata, reg_wr_data;
  logic [8:0]  reg_wr_addr, beam_v, pv;
  logic [7:0]  beam_h, ph;
  logic [3:0]  lat;
  logic [24:0] expq [$];
  logic [24:0] exp_w;
  int          fails, cmp_count, nline, n;
  logic [15:0] w1t [15] = '{16'h000a, 16'h001e, 16'h0001, 16'h0020, 16'h00fe, 16'h7f01,
                            16'h0001, 16'h0180, 16'hff01, 16'h0046, 16'h004a, 16'h00e0,
                            16'h0010, 16'h01fe, 16'hffff};
  // enables all set and waits in rising beam order, except the masked wait and the vertical-only skip
  logic [15:0] w2t [15] = '{16'h0, 16'h0, 16'hfffe, 16'h0, 16'h0, 16'h8000, 16'hffff,
                            16'h0, 16'hff01, 16'h0200, 16'h0, 16'h0, 16'h0, 16'h0, 16'hfffe};

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  dlc_top u_dlc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .beam_h(beam_h), .beam_v(beam_v));
  dlc_mem_model u_dlc_mem_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // one single ahb-lite transfer; upper address bits are random since only 7:0 decode
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    r = xs();
    hsel   <= 1'b1;
    haddr  <= {r[31:8], a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `TB_CHECK("hresp", 0, hresp)
  endtask

  // reference interpreter: beam sits at the top of the field whenever the list runs
  task automatic run_list(input logic [31:0] start, input logic dang);
    logic [31:0] pc;
    logic [15:0] w1, w2;
    logic [8:0]  a;
    logic        hit;
    pc = start;
    for (int i = 0; i < 32; i++) begin
      w1 = u_dlc_mem_model.mem[pc[10:1]];
      w2 = u_dlc_mem_model.mem[pc[10:1] + 10'h1];
      pc = pc + 32'h4;
      a = {w1[8:1], 1'b0};
      hit = (w1[15:8] & {1'b1, w2[14:8]}) == 8'h00;
      if (!w1[0]) begin
        if (a >= 9'h020 || (a >= 9'h010 && dang)) begin
          expq.push_back({a, w2});
          if (a == `DLC_CR_L2L) loc2 = {16'h0000, w2};
          if (a == `DLC_CR_JMP2) pc = loc2;
        end
      end else if (!hit && !w2[0]) begin
        return;
      end else if (hit && w2[0]) begin
        pc = pc + 32'h4;
      end
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    if (hresetn === 1'b1 && reg_wr_strobe === 1'b1) begin
      exp_w = (expq.size() > 0) ? expq.pop_front() : 25'h1ffffff;
      `TB_CHECK("reg_write", exp_w, {reg_wr_addr, reg_wr_data})
    end
  end

  // line lengths alternate long then short; a field ends after line 261
  always @(posedge hclk) begin
    if (hresetn === 1'b1 && !field_done) begin
      if (beam_h < ph) begin
        `TB_CHECK("line_end", nline % 2 ? 8'he2 : 8'he3, ph)
        nline++;
      end
      if (beam_v < pv) begin
        `TB_CHECK("field_end", 9'd261, pv)
        field_done = 1'b1;
      end
      ph = beam_h;
      pv = beam_v;
    end
  end

  initial begin
    repeat (90000) @(posedge hclk);
    fails++;
    complete_run();
  end

  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; lat = 4'h0; seed = 32'd81808; loc2 = 32'h300;
    field_done = 0; ph = 0; pv = 0; nline = 0; fails = 0; cmp_count = 0;
    for (int i = 0; i < 1024; i++) u_dlc_mem_model.mem[i] = xs();
    for (int i = 0; i < 15; i++) begin
      n = (i < 12) ? 'h80 + 2 * i : 'h100 + 2 * (i - 12);
      u_dlc_mem_model.mem[n] = w1t[i];
      u_dlc_mem_model.mem[n + 1] = (w1t[i][0] || i == 9) ? w2t[i] : xs();
    end
    run_list(32'h100, 1'b0);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, `DLC_OFF_CTRL, 0);
    `TB_CHECK("ctrl_reset", 0, rd)
    ahb(1'b1, 8'h30, xs());
    ahb(1'b0, 8'h30, 0);
    `TB_CHECK("unmapped", 0, rd)
    ahb(1'b1, `DLC_OFF_L1LOC, 32'h00000100);
    ahb(1'b1, `DLC_OFF_L2H, 32'h0);
    ahb(1'b1, `DLC_OFF_L2L, 32'h300);
    ahb(1'b0, `DLC_OFF_L1H, 0);
    `TB_CHECK("write_only", 0, rd)
    ahb(1'b1, `DLC_OFF_JMP1, xs());
    ahb(1'b0, `DLC_OFF_STATUS, 0);
    `TB_CHECK("jump_pc", 32'h01000100, rd)
    ahb(1'b1, `DLC_OFF_CFG, 32'h4);
    repeat (200) @(posedge hclk);
    `TB_CHECK("first_pass", 0, expq.size())
    ahb(1'b0, `DLC_OFF_STATUS, 0);
    `TB_CHECK("stop_state", 32'h0800020c, rd)
    n = 0;
    repeat (50) begin
      @(posedge hclk);
      if (mem_req !== 1'b0) n++;
    end
    `TB_CHECK("idle_req", 0, n)
    ahb(1'b1, `DLC_OFF_CTRL, 32'h2);
    ahb(1'b0, `DLC_OFF_CTRL, 0);
    `TB_CHECK("danger_bit", 32'h2, rd)
    rd = xs();
    lat <= 4'(rd % 3 + 1);
    run_list(32'h100, 1'b1);
    for (n = 0; n < 70000 && !field_done; n++) @(posedge hclk);
    repeat (400) @(posedge hclk);
    `TB_CHECK("vblank_rerun", 0, expq.size())
    // pal: every line short; the line in progress at the switch is not measured
    ahb(1'b1, `DLC_OFF_CFG, 32'h1);
    while (beam_h !== 8'h00) @(posedge hclk);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (beam_h !== 8'h00);
      `TB_CHECK("pal_line", 227, n)
    end
    complete_run();
  end
endmodule
